// File: nvcs_pkg.sv
// nvcs_pkg: constants shared by the nvm configuration store control block
// assumes: 12-bit serial-port register addresses, 8-bit register data
package nvcs_pkg;

  // ----------------------------------------------------------------
  // widths and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NVM_AW = 10;
  localparam int unsigned TBL_N  = 23;
  localparam int unsigned IDX_W  = 5;

  localparam logic [ADDR_W-1:0] REG_TBL_FIRST = 12'ha00;
  localparam logic [ADDR_W-1:0] REG_TBL_LAST  = 12'ha16;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 12'hb00;
  localparam logic [ADDR_W-1:0] REG_ERROR     = 12'hb01;
  localparam logic [ADDR_W-1:0] REG_RELOAD    = 12'hb02;
  localparam logic [ADDR_W-1:0] REG_STORE     = 12'hb03;
  localparam logic [ADDR_W-1:0] REG_UPDATE    = 12'h0ff;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned UPDATE_BIT  = 0;
  localparam int unsigned PENDING_BIT = 0;
  localparam int unsigned ERROR_BIT   = 0;
  localparam int unsigned WEN_BIT     = 0;
  localparam int unsigned RELOAD_BIT  = 1;
  localparam int unsigned STORE_BIT   = 0;

  // ----------------------------------------------------------------
  // segment table encoding
  // ----------------------------------------------------------------
  // data segment: [count-1 (bit 7 clear)] [addr high nibble] [addr low byte]
  localparam int unsigned       OPCODE_BIT = 7;
  localparam logic [DATA_W-1:0] OP_UPDATE  = 8'h80;
  localparam logic [DATA_W-1:0] OP_END     = 8'hff;
  localparam logic              WEN_RESET  = 1'b0;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;

  // default walk: five 128-byte segments over 0x000..0x27f, then update, then end
  function automatic logic [DATA_W-1:0] nvcs_tbl_default(input logic [IDX_W-1:0] idx);
    logic [DATA_W-1:0] v;
    v = OP_END;
    case (idx)
      5'h00, 5'h03, 5'h06, 5'h09, 5'h0c: v = 8'h7f;
      5'h01, 5'h02, 5'h04, 5'h08, 5'h0e: v = 8'h00;
      5'h05, 5'h0b:                      v = 8'h80;
      5'h07, 5'h0a:                      v = 8'h01;
      5'h0d:                             v = 8'h02;
      5'h0f:                             v = OP_UPDATE;
      default:                           v = OP_END;
    endcase
    return v;
  endfunction

endpackage

// File: nvcs_ctl_if.sv
// nvcs_ctl_if: control path between register file and table walker
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface nvcs_ctl_if;
  import nvcs_pkg::*;
  logic                start_store;
  logic                start_load;
  logic                busy;
  logic                done;
  logic                err;
  logic                upd;
  logic [IDX_W-1:0]    tbl_idx;
  logic [DATA_W-1:0]   tbl_data;

  modport ctrl (output start_store, output start_load, output tbl_data,
                input busy, input done, input err, input upd, input tbl_idx);
  modport eng  (input start_store, input start_load, input tbl_data,
                output busy, output done, output err, output upd, output tbl_idx);
endinterface
`default_nettype wire

// File: nvcs_walker.sv
// nvcs_walker: walks the segment table, moves bytes buffer <-> nvm with checksum
// assumes: nvm answers each request with a one-cycle ack, buffer reads are combinational
`timescale 1ns/1ps
`default_nettype none
module nvcs_walker
  import nvcs_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_ni,
  // control
  nvcs_ctl_if.eng                  ctl,
  // buffer registers
  output logic [ADDR_W-1:0]        buf_addr_o,
  output logic                     buf_we_o,
  output logic [DATA_W-1:0]        buf_wdata_o,
  input  wire logic [DATA_W-1:0]   buf_rdata_i,
  // nonvolatile memory
  output logic                     nvm_req_o,
  output logic                     nvm_we_o,
  output logic [NVM_AW-1:0]        nvm_addr_o,
  output logic [DATA_W-1:0]        nvm_wdata_o,
  input  wire logic [DATA_W-1:0]   nvm_rdata_i,
  input  wire logic                nvm_ack_i
);

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_AHI   = 3'b010,
    S_ALO   = 3'b011,
    S_LATCH = 3'b100,
    S_XFER  = 3'b101,
    S_BWR   = 3'b110,
    S_DONE  = 3'b111
  } nvcs_state_t;

  nvcs_state_t       state_q;
  logic              store_q;
  logic              last_q;
  logic              err_q;
  logic [IDX_W-1:0]  idx_q;
  logic [6:0]        cnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic [NVM_AW-1:0] naddr_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] sum_q;
  logic [DATA_W-1:0] entry;
  logic              seg_last;

  // past the table counts as end-of-data
  assign entry    = (idx_q >= IDX_W'(TBL_N)) ? OP_END : ctl.tbl_data;
  assign seg_last = (cnt_q == 7'h00);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      state_q <= S_IDLE;
      store_q <= 1'b0;
      last_q  <= 1'b0;
      idx_q   <= '0;
      cnt_q   <= '0;
      addr_q  <= '0;
      naddr_q <= '0;
      data_q  <= '0;
      sum_q   <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (ctl.start_store || ctl.start_load) begin
            state_q <= S_FETCH;
            store_q <= ctl.start_store;
            last_q  <= 1'b0;
            idx_q   <= '0;
            naddr_q <= '0;
            sum_q   <= '0;
          end
        end
        S_FETCH: begin
          if (entry[OPCODE_BIT] && entry != OP_UPDATE) begin
            last_q  <= 1'b1;
            data_q  <= sum_q;
            state_q <= S_XFER;
          end else if (entry[OPCODE_BIT]) begin
            idx_q <= idx_q + 1'b1;
          end else begin
            cnt_q   <= entry[6:0];
            idx_q   <= idx_q + 1'b1;
            state_q <= S_AHI;
          end
        end
        S_AHI: begin
          addr_q[ADDR_W-1:8] <= entry[3:0];
          idx_q              <= idx_q + 1'b1;
          state_q            <= S_ALO;
        end
        S_ALO: begin
          addr_q[7:0] <= entry;
          idx_q       <= idx_q + 1'b1;
          state_q     <= store_q ? S_LATCH : S_XFER;
        end
        S_LATCH: begin
          data_q  <= buf_rdata_i;
          state_q <= S_XFER;
        end
        S_XFER: begin
          if (nvm_ack_i) begin
            naddr_q <= naddr_q + 1'b1;
            if (last_q) begin
              state_q <= S_DONE;
            end else if (store_q) begin
              sum_q <= sum_q ^ data_q;
              if (seg_last) begin
                state_q <= S_FETCH;
              end else begin
                cnt_q   <= cnt_q - 1'b1;
                addr_q  <= addr_q + 1'b1;
                state_q <= S_LATCH;
              end
            end else begin
              data_q  <= nvm_rdata_i;
              sum_q   <= sum_q ^ nvm_rdata_i;
              state_q <= S_BWR;
            end
          end
        end
        S_BWR: begin
          if (seg_last) begin
            state_q <= S_FETCH;
          end else begin
            cnt_q   <= cnt_q - 1'b1;
            addr_q  <= addr_q + 1'b1;
            state_q <= S_XFER;
          end
        end
        S_DONE:  state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // checksum byte closes every image; a mismatch on load flags bad data
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      err_q <= 1'b0;
    end else if (state_q == S_IDLE && (ctl.start_store || ctl.start_load)) begin
      err_q <= 1'b0;
    end else if (state_q == S_XFER && nvm_ack_i && last_q && !store_q) begin
      err_q <= (nvm_rdata_i != sum_q);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ctl.busy    = (state_q != S_IDLE);
  assign ctl.done    = (state_q == S_DONE);
  assign ctl.err     = err_q;
  assign ctl.tbl_idx = idx_q;
  // update opcode only acts on a load; a store just skips it
  assign ctl.upd     = (state_q == S_FETCH) && (entry == OP_UPDATE) && !store_q;
  assign buf_addr_o  = addr_q;
  assign buf_we_o    = (state_q == S_BWR);
  assign buf_wdata_o = data_q;
  assign nvm_req_o   = (state_q == S_XFER);
  assign nvm_we_o    = (state_q == S_XFER) && store_q;
  assign nvm_addr_o  = naddr_q;
  assign nvm_wdata_o = data_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_ni);

  a_req_held_stable: assert property (
    nvm_req_o && !nvm_ack_i |=> nvm_req_o && $stable(nvm_addr_o) && $stable(nvm_we_o))
    else $error("nvm request dropped or changed before ack");
  a_end_goes_sum: assert property (
    state_q == S_FETCH && entry == OP_END |=> nvm_req_o && last_q)
    else $error("end marker did not start checksum access");
  a_load_no_write: assert property (
    !store_q |-> !nvm_we_o)
    else $error("nvm written during a load");

endmodule
`default_nettype wire

// File: nvcs_top.sv
// nvcs_top: nvm configuration store control, register file and command logic
// assumes: serial-port decoder gives one-cycle register strobes and a serial clock tick
`timescale 1ns/1ps
`default_nettype none
module nvcs_top
  import nvcs_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  // register access from the serial port
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [nvcs_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [nvcs_pkg::DATA_W-1:0] reg_wdata_i,
  output logic      [nvcs_pkg::DATA_W-1:0] reg_rdata_o,
  input  wire logic                        sclk_tick_i,
  // pins and device-wide effects
  input  wire logic                        boot_sel_i,
  output logic                             update_all_o,
  output logic                             soft_reset_o,
  // buffer registers
  output logic      [nvcs_pkg::ADDR_W-1:0] buf_addr_o,
  output logic                             buf_we_o,
  output logic      [nvcs_pkg::DATA_W-1:0] buf_wdata_o,
  input  wire logic [nvcs_pkg::DATA_W-1:0] buf_rdata_i,
  // nonvolatile memory
  output logic                             nvm_req_o,
  output logic                             nvm_we_o,
  output logic      [nvcs_pkg::NVM_AW-1:0] nvm_addr_o,
  output logic      [nvcs_pkg::DATA_W-1:0] nvm_wdata_o,
  input  wire logic [nvcs_pkg::DATA_W-1:0] nvm_rdata_i,
  input  wire logic                        nvm_ack_i
);
  import nvcs_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rsync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic nvcs_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
    return a == t;
  endfunction

  nvcs_ctl_if ctl ();

  logic [DATA_W-1:0] tbl_q [TBL_N];
  logic              wen_q;
  logic              reload_q;
  logic              store_q;
  logic              upd_q;
  logic              soft_q;
  logic              start_store_q;
  logic              start_load_q;
  logic [DATA_W-1:0] rdata_q;
  logic              tbl_hit;
  logic [IDX_W-1:0]  tbl_wr_idx;
  logic              wr_reload;
  logic              wr_store;
  logic              wr_update;
  logic              reload_fire;

  assign tbl_hit    = reg_addr_i >= REG_TBL_FIRST && reg_addr_i <= REG_TBL_LAST;
  assign tbl_wr_idx = IDX_W'(reg_addr_i - REG_TBL_FIRST);
  assign wr_reload  = reg_wr_i && nvcs_hit(reg_addr_i, REG_RELOAD);
  assign wr_store   = reg_wr_i && nvcs_hit(reg_addr_i, REG_STORE) && reg_wdata_i[STORE_BIT];
  assign wr_update  = reg_wr_i && nvcs_hit(reg_addr_i, REG_UPDATE) && reg_wdata_i[UPDATE_BIT];
  // write is over once no strobe is present; the next serial tick acts
  assign reload_fire = reload_q && sclk_tick_i && !wr_reload;

  // ----------------------------------------------------------------
  // segment table
  // ----------------------------------------------------------------
  // frozen while a walk runs so the walker never sees a half-edited segment
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < TBL_N; i++) begin
        tbl_q[i] <= nvcs_tbl_default(IDX_W'(i));
      end
    end else if (reg_wr_i && tbl_hit && !ctl.busy) begin
      tbl_q[tbl_wr_idx] <= reg_wdata_i;
    end
  end
  assign ctl.tbl_data = tbl_q[ctl.tbl_idx];

  // ----------------------------------------------------------------
  // write protection and reload
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wen_q <= WEN_RESET;
    end else if (soft_q) begin
      wen_q <= WEN_RESET;
    end else if (wr_reload) begin
      wen_q <= reg_wdata_i[WEN_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= 1'b0;
    end else if (wr_reload && reg_wdata_i[RELOAD_BIT]) begin
      reload_q <= 1'b1;
    end else if (reload_fire) begin
      reload_q <= 1'b0;
    end
  end

  // boot pin high means pin-selected settings: the bit just clears
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      soft_q       <= 1'b0;
      start_load_q <= 1'b0;
    end else begin
      soft_q       <= reload_fire && !boot_sel_i;
      start_load_q <= soft_q && !ctl.busy;
    end
  end

  // ----------------------------------------------------------------
  // store and update commands
  // ----------------------------------------------------------------
  // a protected or overlapping store never sets the bit; it reads 0 unless an earlier store is still running
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      store_q       <= 1'b0;
      start_store_q <= 1'b0;
    end else begin
      start_store_q <= wr_store && wen_q && !ctl.busy && !store_q;
      if (wr_store && wen_q && !ctl.busy && !store_q) begin
        store_q <= 1'b1;
      end else if (ctl.done) begin
        store_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= wr_update || ctl.upd;
    end
  end

  assign ctl.start_store = start_store_q;
  assign ctl.start_load  = start_load_q;

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= ZERO_BYTE;
    end else if (reg_rd_i) begin
      rdata_q <= ZERO_BYTE;
      if (tbl_hit) begin
        rdata_q <= tbl_q[tbl_wr_idx];
      end else if (nvcs_hit(reg_addr_i, REG_STATUS)) begin
        rdata_q[PENDING_BIT] <= ctl.busy;
      end else if (nvcs_hit(reg_addr_i, REG_ERROR)) begin
        rdata_q[ERROR_BIT] <= ctl.err;
      end else if (nvcs_hit(reg_addr_i, REG_RELOAD)) begin
        rdata_q[WEN_BIT]    <= wen_q;
        rdata_q[RELOAD_BIT] <= reload_q;
      end else if (nvcs_hit(reg_addr_i, REG_STORE)) begin
        rdata_q[STORE_BIT] <= store_q;
      end
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign update_all_o = upd_q;
  assign soft_reset_o = soft_q;

  // ----------------------------------------------------------------
  // walker
  // ----------------------------------------------------------------
  nvcs_walker u_walker (
    .clk_i       (clk_i),
    .rst_ni      (rst_n),
    .ctl         (ctl.eng),
    .buf_addr_o  (buf_addr_o),
    .buf_we_o    (buf_we_o),
    .buf_wdata_o (buf_wdata_o),
    .buf_rdata_i (buf_rdata_i),
    .nvm_req_o   (nvm_req_o),
    .nvm_we_o    (nvm_we_o),
    .nvm_addr_o  (nvm_addr_o),
    .nvm_wdata_o (nvm_wdata_o),
    .nvm_rdata_i (nvm_rdata_i),
    .nvm_ack_i   (nvm_ack_i)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_reload_seq;
    soft_reset_o ##1 (start_load_q || $past(ctl.busy));
  endsequence

  a_update_pulse: assert property (
    wr_update |=> update_all_o)
    else $error("update-all write gave no update pulse");
  a_update_reads_zero: assert property (
    reg_rd_i && nvcs_hit(reg_addr_i, REG_UPDATE) |=> reg_rdata_o == ZERO_BYTE)
    else $error("update-all bit did not read back as zero");
  a_table_write: assert property (
    reg_wr_i && tbl_hit && !ctl.busy |=> tbl_q[$past(tbl_wr_idx)] == $past(reg_wdata_i))
    else $error("segment entry not written");
  a_pending_flag: assert property (
    reg_rd_i && nvcs_hit(reg_addr_i, REG_STATUS)
      |=> reg_rdata_o[PENDING_BIT] == $past(ctl.busy))
    else $error("pending flag does not follow transfer");
  a_error_flag: assert property (
    reg_rd_i && nvcs_hit(reg_addr_i, REG_ERROR) |=> reg_rdata_o[ERROR_BIT] == $past(ctl.err))
    else $error("error flag does not follow check result");
  a_soft_reload: assert property (
    reload_fire && !boot_sel_i |=> s_reload_seq)
    else $error("reload did not reset and start a load");
  a_reload_clear: assert property (
    reload_fire |=> !reload_q)
    else $error("reload bit not cleared on serial tick");
  a_store_gated: assert property (
    $rose(ctl.busy) && store_q |-> $past(wen_q))
    else $error("store ran while write protected");
  a_store_start: assert property (
    wr_store && wen_q && !ctl.busy && !store_q |=> store_q ##1 (ctl.busy && nvm_we_o == 1'b0))
    else $error("store command did not start a copy");
  a_store_clear: assert property (
    store_q && ctl.done |=> !store_q)
    else $error("store bit stuck after copy");
  a_store_protect: assert property (
    wr_store && !wen_q && !store_q |=> !store_q ##1 !start_store_q)
    else $error("protected store was accepted");

endmodule
`default_nettype wire

// File: nvcs_partner.sv
// nvcs_partner: buffer register and nonvolatile memory models
// assumes: design holds each nvm request until it samples the ack
`timescale 1ns/1ps
`default_nettype none
module nvcs_partner
  import nvcs_pkg::*;
(
  // clock and pacing
  input  wire logic              clk_i,
  input  wire logic [3:0]        lat_i,
  // buffer registers
  input  wire logic [ADDR_W-1:0] buf_addr_i,
  input  wire logic              buf_we_i,
  input  wire logic [DATA_W-1:0] buf_wdata_i,
  output logic      [DATA_W-1:0] buf_rdata_o,
  // nonvolatile memory
  input  wire logic              nvm_req_i,
  input  wire logic              nvm_we_i,
  input  wire logic [NVM_AW-1:0] nvm_addr_i,
  input  wire logic [DATA_W-1:0] nvm_wdata_i,
  output logic      [DATA_W-1:0] nvm_rdata_o,
  output logic                   nvm_ack_o
);
  logic [DATA_W-1:0] bufm [256];
  logic [DATA_W-1:0] mem  [1024];
  logic [DATA_W-1:0] rd_q  = 8'h00;
  logic [3:0]        cnt_q = 4'h0;
  logic              ack_q = 1'b0;
  initial begin
    for (int i = 0; i < 256; i++) bufm[i] = 8'(i) ^ 8'h5a;
    for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
  end
  assign buf_rdata_o = bufm[buf_addr_i[7:0]];
  assign nvm_ack_o   = ack_q;
  // idle data shows the inverse so a late sample is caught
  assign nvm_rdata_o = ack_q ? rd_q : ~rd_q;
  always @(posedge clk_i) begin
    if (buf_we_i) bufm[buf_addr_i[7:0]] <= buf_wdata_i;
  end
  // ack lat_i+1 cycles after the request, one cycle wide
  always @(posedge clk_i) begin
    if (ack_q) begin
      ack_q <= 1'b0;
    end else if (nvm_req_i && cnt_q == lat_i) begin
      ack_q <= 1'b1;
      cnt_q <= 4'h0;
      if (nvm_we_i) mem[nvm_addr_i] <= nvm_wdata_i;
      else rd_q <= mem[nvm_addr_i];
    end else if (nvm_req_i) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// testbench: register-level tests of the nvm configuration store control
// assumes: nvcs_partner stands for buffer registers and nvm
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvcs_pkg::*;
  logic        clk, nrst, wr_s, rd_s, tick, boot, upd, srst;
  logic        bwe, req, nwe, ack;
  logic [11:0] addr, baddr;
  logic [9:0]  naddr;
  logic [7:0]  wdata, rdata, bwdata, brdata, nwdata, nrdata, v;
  logic [3:0]  lat;
  int          failures = 0;
  int          n_tests = 0;
  int          n_upd = 0;
  int          n0;

  nvcs_top u_nvcs_top (.clk_i(clk), .nrst_i(nrst), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sclk_tick_i(tick),
    .boot_sel_i(boot), .update_all_o(upd), .soft_reset_o(srst), .buf_addr_o(baddr),
    .buf_we_o(bwe), .buf_wdata_o(bwdata), .buf_rdata_i(brdata), .nvm_req_o(req),
    .nvm_we_o(nwe), .nvm_addr_o(naddr), .nvm_wdata_o(nwdata), .nvm_rdata_i(nrdata),
    .nvm_ack_i(ack));
  nvcs_partner u_nvcs_partner (.clk_i(clk), .lat_i(lat), .buf_addr_i(baddr),
    .buf_we_i(bwe), .buf_wdata_i(bwdata), .buf_rdata_o(brdata), .nvm_req_i(req),
    .nvm_we_i(nwe), .nvm_addr_i(naddr), .nvm_wdata_i(nwdata), .nvm_rdata_o(nrdata),
    .nvm_ack_o(ack));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (upd === 1'b1) n_upd <= n_upd + 1;

  // ----
  // register port tasks
  // ----
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wait_idle;
    repeat (3000) begin
      rd(REG_STATUS, v);
      if (v === 8'h00) break;
    end
    chk(v, 8'h00, "pending");
  endtask
  // reload from nvm with boot pin low; tick comes after the write
  task automatic load(input logic [7:0] err);
    boot = 1'b0;
    n0 = n_upd;
    wr(REG_RELOAD, 8'h02);
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (4) begin
      if (srst === 1'b1) break;
      @(negedge clk);
    end
    chk(8'(srst), 8'h01, "soft reset");
    rd(REG_RELOAD, v);
    chk(v, 8'h00, "reload bit");
    wait_idle();
    chk(8'(n_upd - n0), 8'h01, "op update");
    rd(REG_ERROR, v);
    chk(v, err, "data error");
  endtask
  task print_verdict;
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    print_verdict();
  end

  initial begin
    {nrst, wr_s, rd_s, tick, addr, wdata} = '0;
    boot = 1'b1;
    lat = 4'h3;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rd(REG_TBL_FIRST, v);
    chk(v, 8'h7f, "tbl first");
    rd(12'ha0f, v);
    chk(v, OP_UPDATE, "tbl update op");
    rd(REG_TBL_LAST, v);
    chk(v, OP_END, "tbl last");
    rd(REG_STATUS, v);
    chk(v, 8'h00, "pending");
    rd(REG_RELOAD, v);
    chk(v, 8'h00, "write enable");
    rd(12'ha17, v);
    chk(v, 8'h00, "past table");
    wr(REG_UPDATE, 8'h01);
    chk(8'(upd), 8'h01, "update");
    @(negedge clk);
    chk(8'(upd), 8'h00, "update end");
    rd(REG_UPDATE, v);
    chk(v, 8'h00, "update bit");
    wr(REG_STORE, 8'h01);
    repeat (40) @(negedge clk);
    rd(REG_STORE, v);
    chk(v, 8'h00, "store refused");
    chk(u_nvcs_partner.mem[0], 8'h00, "nvm protected");
    // short table: 3 bytes from 0x010, update, end
    wr(12'ha00, 8'h02);
    wr(12'ha01, 8'h00);
    wr(12'ha02, 8'h10);
    wr(12'ha03, OP_UPDATE);
    wr(12'ha04, OP_END);
    wr(REG_TBL_LAST, 8'h55);
    rd(REG_TBL_LAST, v);
    chk(v, 8'h55, "tbl rw");
    wr(REG_RELOAD, 8'h01);
    n0 = n_upd;
    wr(REG_STORE, 8'h01);
    rd(REG_STORE, v);
    chk(v, 8'h01, "store bit");
    rd(REG_STATUS, v);
    chk(v, 8'h01, "pending busy");
    // table write while the walk runs must be dropped
    wr(12'ha05, 8'h33);
    wait_idle();
    rd(REG_STORE, v);
    chk(v, 8'h00, "store clear");
    chk(8'(n_upd - n0), 8'h00, "store skips update");
    chk(u_nvcs_partner.mem[3], 8'h49, "nvm checksum");
    rd(12'ha05, v);
    chk(v, 8'h80, "tbl frozen");
    for (int i = 0; i < 3; i++) begin
      chk(u_nvcs_partner.mem[i], 8'(16 + i) ^ 8'h5a, "nvm data");
      u_nvcs_partner.bufm[16 + i] = 8'h00;
    end
    lat = 4'h0;
    load(8'h00);
    for (int i = 0; i < 3; i++) chk(u_nvcs_partner.bufm[16 + i], 8'(16 + i) ^ 8'h5a, "buf");
    u_nvcs_partner.mem[1] = u_nvcs_partner.mem[1] ^ 8'h01;
    load(8'h01);
    // boot pin high: reload bit only clears, no soft reset
    boot = 1'b1;
    wr(REG_RELOAD, 8'h02);
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    chk(8'(srst), 8'h00, "boot high reset");
    rd(REG_RELOAD, v);
    chk(v, 8'h00, "boot high reload bit");
    print_verdict();
  end
endmodule
`default_nettype wire
